// *** common/dewc_pkg.sv ***
// shared constants and types of the data eeprom write controller
package dewc_pkg;

  // control/status register location and layout
  localparam logic [15:0] CSR_ADDR = 16'h0030;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int LATCH_MODE_BIT = 1;
  localparam int PROG_START_BIT = 0;

  // eeprom window on the cpu memory bus
  localparam logic [15:0] EE_BASE = 16'h1000;
  localparam int EE_DEPTH = 256;
  localparam int ROW_BYTES = 32;

  // cell and latch value after erase, and what protected read-out returns
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] BLOCKED_DATA = 8'h00;

  // self-timed programming duration in clock cycles
  localparam int PROG_CYCLES = 4000;

  // one cpu memory access, valid for one cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic ext;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dewc_bus_t;

  // registered answer to a read
  typedef struct packed {
    logic drive;
    logic [7:0] rdata;
  } dewc_rsp_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_PROG,
    S_WAIT,
    S_HALT
  } dewc_state_t;

endpackage

// *** hw/dewc_array.sv ***
// eeprom cell array: asynchronous read, row program and whole-array erase
`timescale 1ns/100ps
module dewc_array #(
  parameter int DEPTH = dewc_pkg::EE_DEPTH,
  parameter int ROW_BYTES = dewc_pkg::ROW_BYTES
) (
  input wire logic i_clk,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_prog,
  input wire logic [$clog2(DEPTH)-$clog2(ROW_BYTES)-1:0] i_row,
  input wire logic [ROW_BYTES*8-1:0] i_data,
  input wire logic [ROW_BYTES-1:0] i_mask,
  input wire logic i_erase
);

  localparam int CW = $clog2(ROW_BYTES);

  // nonvolatile cells: deliberately no reset
  logic [7:0] mem_r [DEPTH];

  // read path is combinational so the controller can answer on the next edge
  always_comb begin
    o_rd_data = mem_r[i_rd_addr];
  end

  // erase outranks programming; only bytes loaded since the last clear are written
  always_ff @(posedge i_clk) begin
    if (i_erase) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= dewc_pkg::ERASED;
      end
    end else if (i_prog) begin
      for (int b = 0; b < ROW_BYTES; b++) begin
        if (i_mask[b]) begin
          mem_r[{i_row, CW'(b)}] <= i_data[b*8 +: 8];
        end
      end
    end
  end

endmodule

// *** hw/dewc_ctrl.sv ***
// data eeprom write controller: bus decode, row latches, program timer, power modes
//
// Contract
// - in read mode an eeprom read returns the addressed byte on the next edge.
// - setting latch mode enters write mode; eeprom writes load one of 32 latches.
// - start bit programs all loaded latches into the row of the last write.
// - at cycle end start bit and latch mode bit clear together.
// - latches clear only at cycle end or latch-mode fall; rewrites AND together.
// - latch contents can never be read back.
// - programming duration is timed internally.
// - wait request enters wait at once when idle, else after the cycle.
// - halt stops at once, abandoning a running cycle.
// - eeprom read in latch mode leaves the data bus undriven.
// - eeprom write outside latch mode is ignored.
// - a cut-short cycle leaves the row contents unspecified.
// - protection blocks external read-out and external rewriting.
// - removing protection erases the whole eeprom and program memory first.
// - one shared option bit protects both memories.
// - status bits 7:2 always read zero.
// - latch mode is bit 1; software clears it only while start bit is 0.
// - start bit is bit 0; reads 1 while a cycle runs.
// - status register sits at 0030h and resets to 00h.
`timescale 1ns/100ps
module dewc_ctrl #(
  parameter int EE_DEPTH = dewc_pkg::EE_DEPTH,
  parameter int ROW_BYTES = dewc_pkg::ROW_BYTES,
  parameter int PROG_CYCLES = dewc_pkg::PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire dewc_pkg::dewc_bus_t i_bus,
  input wire logic i_wait_req,
  input wire logic i_halt,
  input wire logic i_rop_option,
  output dewc_pkg::dewc_rsp_t o_rsp,
  output logic o_wait_ack,
  output logic o_busy,
  output logic o_pmem_erase
);

  localparam int AW = $clog2(EE_DEPTH);
  localparam int CW = $clog2(ROW_BYTES);
  localparam int RW = AW - CW;
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] PROG_LOAD = TW'(PROG_CYCLES);
  localparam logic [TW-1:0] TIMER_LAST = TW'(1);

  // refuse shapes the address split and timer cannot serve
  if ((ROW_BYTES < 2) || (ROW_BYTES != (1 << CW)) || (EE_DEPTH != (1 << AW)) ||
      (EE_DEPTH <= ROW_BYTES) || (EE_DEPTH > 32768) || (PROG_CYCLES < 2)) begin : g_bad
    $error("dewc_ctrl: unsupported EE_DEPTH, ROW_BYTES or PROG_CYCLES");
  end

  // address decode, used for both reads and writes
  function automatic logic hit_ee(input logic [15:0] a);
    hit_ee = ({16'h0000, a} >= {16'h0000, dewc_pkg::EE_BASE}) &&
             ({16'h0000, a} < ({16'h0000, dewc_pkg::EE_BASE} + 32'(EE_DEPTH)));
  endfunction

  function automatic logic hit_csr(input logic [15:0] a);
    hit_csr = (a == dewc_pkg::CSR_ADDR);
  endfunction

  // state
  dewc_pkg::dewc_state_t state_r, state_nxt;
  logic latch_mode_r, latch_mode_nxt;
  logic prog_start_r, prog_start_nxt;
  logic [TW-1:0] timer_r, timer_nxt;
  logic [7:0] ldata_r [ROW_BYTES];
  logic [7:0] ldata_nxt [ROW_BYTES];
  logic [ROW_BYTES-1:0] lvld_r, lvld_nxt;
  logic [RW-1:0] row_r, row_nxt;
  dewc_pkg::dewc_rsp_t rsp_r, rsp_nxt;
  logic wait_ack_r, wait_ack_nxt;
  logic erase_r, erase_nxt;
  logic rop_s1_r, rop_s2_r, rop_d_r;

  // decode and event terms
  logic [15:0] ee_off;
  logic [AW-1:0] ee_idx;
  logic rop_blk, rop_fall, ext_blk;
  logic ee_wr, ee_rd, csr_wr, csr_rd;
  logic start, done, abort, lclear;
  logic [7:0] arr_rd;
  logic [ROW_BYTES*8-1:0] lflat;

  // one option bit guards both memories; held blocked through the fall cycle
  // so an external read cannot slip in before the erase lands
  always_comb begin
    rop_blk = rop_s2_r | rop_d_r;
    rop_fall = rop_d_r & ~rop_s2_r;
    ext_blk = i_bus.ext & rop_blk;
    ee_off = i_bus.addr - dewc_pkg::EE_BASE;
    ee_idx = ee_off[AW-1:0];
    ee_wr = i_bus.wr & hit_ee(i_bus.addr) & ~ext_blk;
    ee_rd = i_bus.rd & hit_ee(i_bus.addr);
    csr_wr = i_bus.wr & hit_csr(i_bus.addr) & ~ext_blk;
    csr_rd = i_bus.rd & hit_csr(i_bus.addr);
  end

  // cycle control: start only from idle with write mode already on
  always_comb begin
    start = csr_wr & i_bus.wdata[dewc_pkg::PROG_START_BIT] & latch_mode_r &
            (state_r == dewc_pkg::S_IDLE) & ~i_halt;
    done = (state_r == dewc_pkg::S_PROG) & (timer_r == TIMER_LAST) & ~i_halt;
    // halt or software clearing the start bit cuts the cycle; cells are not written
    abort = (state_r == dewc_pkg::S_PROG) & ~done &
            (i_halt | (csr_wr & ~i_bus.wdata[dewc_pkg::PROG_START_BIT]));
  end

  // power-mode and cycle sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dewc_pkg::S_IDLE: begin
        if (i_halt) begin
          state_nxt = dewc_pkg::S_HALT;
        end else if (start) begin
          state_nxt = dewc_pkg::S_PROG;
        end else if (i_wait_req) begin
          state_nxt = dewc_pkg::S_WAIT;
        end
      end
      dewc_pkg::S_PROG: begin
        if (i_halt) begin
          state_nxt = dewc_pkg::S_HALT;
        end else if (done) begin
          state_nxt = i_wait_req ? dewc_pkg::S_WAIT : dewc_pkg::S_IDLE;
        end else if (abort) begin
          state_nxt = dewc_pkg::S_IDLE;
        end
      end
      dewc_pkg::S_WAIT: begin
        if (i_halt) begin
          state_nxt = dewc_pkg::S_HALT;
        end else if (!i_wait_req) begin
          state_nxt = dewc_pkg::S_IDLE;
        end
      end
      dewc_pkg::S_HALT: begin
        if (!i_halt) begin
          state_nxt = dewc_pkg::S_IDLE;
        end
      end
      default: begin
        state_nxt = dewc_pkg::S_IDLE;
      end
    endcase
    wait_ack_nxt = (state_nxt == dewc_pkg::S_WAIT);
  end

  // control bits and timer
  always_comb begin
    prog_start_nxt = prog_start_r;
    latch_mode_nxt = latch_mode_r;
    timer_nxt = timer_r;
    if (csr_wr) begin
      if (i_bus.wdata[dewc_pkg::LATCH_MODE_BIT]) begin
        latch_mode_nxt = 1'b1;
      end else if (!prog_start_r && !i_bus.wdata[dewc_pkg::PROG_START_BIT]) begin
        latch_mode_nxt = 1'b0;
      end
    end
    if (start) begin
      prog_start_nxt = 1'b1;
      timer_nxt = PROG_LOAD;
    end else if (done || abort) begin
      prog_start_nxt = 1'b0;
      timer_nxt = '0;
    end else if ((state_r == dewc_pkg::S_PROG) && (timer_r != '0)) begin
      timer_nxt = timer_r - TIMER_LAST;
    end
    if (done) begin
      prog_start_nxt = 1'b0;
      latch_mode_nxt = 1'b0;
    end
  end

  // row latches: erased value is all ones, so a rewrite ANDs into what is held
  always_comb begin
    lclear = done | (latch_mode_r & ~latch_mode_nxt);
    lvld_nxt = lvld_r;
    row_nxt = row_r;
    for (int b = 0; b < ROW_BYTES; b++) begin
      ldata_nxt[b] = ldata_r[b];
    end
    if (lclear) begin
      lvld_nxt = '0;
      for (int b = 0; b < ROW_BYTES; b++) begin
        ldata_nxt[b] = dewc_pkg::ERASED;
      end
    end else if (ee_wr && latch_mode_r) begin
      // only the low address bits pick a latch; the row follows the last write
      ldata_nxt[ee_idx[CW-1:0]] = ldata_r[ee_idx[CW-1:0]] & i_bus.wdata;
      lvld_nxt[ee_idx[CW-1:0]] = 1'b1;
      row_nxt = ee_idx[AW-1:CW];
    end
  end

  // flatten latches for the array program port
  always_comb begin
    for (int b = 0; b < ROW_BYTES; b++) begin
      lflat[b*8 +: 8] = ldata_r[b];
    end
  end

  // read answer; latches have no path here at all
  always_comb begin
    rsp_nxt = '0;
    erase_nxt = rop_fall;
    if (csr_rd) begin
      rsp_nxt.drive = 1'b1;
      rsp_nxt.rdata = {6'h00, latch_mode_r, prog_start_r};
    end else if (ee_rd) begin
      if (latch_mode_r) begin
        rsp_nxt.drive = 1'b0;
      end else if (ext_blk) begin
        rsp_nxt.drive = 1'b1;
        rsp_nxt.rdata = dewc_pkg::BLOCKED_DATA;
      end else begin
        rsp_nxt.drive = 1'b1;
        rsp_nxt.rdata = arr_rd;
      end
    end
  end

  // cell array; a completed cycle writes the row, protection removal erases all
  dewc_array #(
    .DEPTH(EE_DEPTH),
    .ROW_BYTES(ROW_BYTES)
  ) u_array (
    .i_clk(i_clk),
    .i_rd_addr(ee_idx),
    .o_rd_data(arr_rd),
    .i_prog(done),
    .i_row(row_r),
    .i_data(lflat),
    .i_mask(lvld_r),
    .i_erase(rop_fall)
  );

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= dewc_pkg::S_IDLE;
      latch_mode_r <= dewc_pkg::CSR_RESET[dewc_pkg::LATCH_MODE_BIT];
      prog_start_r <= dewc_pkg::CSR_RESET[dewc_pkg::PROG_START_BIT];
      timer_r <= '0;
      lvld_r <= '0;
      row_r <= '0;
      rsp_r <= '0;
      wait_ack_r <= 1'b0;
      erase_r <= 1'b0;
      rop_s1_r <= 1'b1;
      rop_s2_r <= 1'b1;
      rop_d_r <= 1'b1;
      for (int b = 0; b < ROW_BYTES; b++) begin
        ldata_r[b] <= dewc_pkg::ERASED;
      end
    end else begin
      state_r <= state_nxt;
      latch_mode_r <= latch_mode_nxt;
      prog_start_r <= prog_start_nxt;
      timer_r <= timer_nxt;
      lvld_r <= lvld_nxt;
      row_r <= row_nxt;
      rsp_r <= rsp_nxt;
      wait_ack_r <= wait_ack_nxt;
      erase_r <= erase_nxt;
      // option bit is static logic but synchronised anyway; resets protected
      rop_s1_r <= i_rop_option;
      rop_s2_r <= rop_s1_r;
      rop_d_r <= rop_s2_r;
      for (int b = 0; b < ROW_BYTES; b++) begin
        ldata_r[b] <= ldata_nxt[b];
      end
    end
  end

  assign o_rsp = rsp_r;
  assign o_wait_ack = wait_ack_r;
  assign o_busy = prog_start_r;
  assign o_pmem_erase = erase_r;

  // checks
  property p_rd_rom;
    @(posedge i_clk) disable iff (i_reset)
    (ee_rd && !csr_rd && !latch_mode_r && !ext_blk)
      |=> (o_rsp.drive && o_rsp.rdata == $past(arr_rd));
  endproperty
  a_rd_rom: assert property (p_rd_rom) else $error("eeprom read data wrong");

  property p_rd_float;
    @(posedge i_clk) disable iff (i_reset)
    (ee_rd && latch_mode_r) |=> !o_rsp.drive;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("bus driven in latch mode");

  property p_no_capture;
    @(posedge i_clk) disable iff (i_reset)
    (ee_wr && !latch_mode_r) |=> $stable(lvld_r);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("latch loaded in read mode");

  property p_end_clear;
    @(posedge i_clk) disable iff (i_reset)
    (state_r == dewc_pkg::S_PROG && timer_r == TIMER_LAST && !i_halt)
      |=> (!prog_start_r && !latch_mode_r && lvld_r == '0);
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("cycle end did not clear");

  property p_and_merge;
    @(posedge i_clk) disable iff (i_reset)
    (ee_wr && latch_mode_r && !lclear) |=>
      (ldata_r[$past(ee_idx[CW-1:0])] ==
       ($past(ldata_r[ee_idx[CW-1:0]]) & $past(i_bus.wdata)));
  endproperty
  a_and_merge: assert property (p_and_merge) else $error("latch rewrite not ANDed");

  property p_csr_read;
    @(posedge i_clk) disable iff (i_reset)
    csr_rd |=> (o_rsp.drive &&
                o_rsp.rdata == {6'h00, $past(latch_mode_r), $past(prog_start_r)});
  endproperty
  a_csr_read: assert property (p_csr_read) else $error("status read wrong");

  property p_wmode_hold;
    @(posedge i_clk) disable iff (i_reset)
    (csr_wr && !i_bus.wdata[dewc_pkg::LATCH_MODE_BIT] && prog_start_r && !done)
      |=> latch_mode_r;
  endproperty
  a_wmode_hold: assert property (p_wmode_hold) else $error("latch mode cleared while busy");

  property p_prog_len;
    @(posedge i_clk) disable iff (i_reset)
    start |=> (prog_start_r && timer_r == PROG_LOAD);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("timer not loaded at start");

  property p_halt_abort;
    @(posedge i_clk) disable iff (i_reset)
    (i_halt && prog_start_r) |=> (!prog_start_r && state_r == dewc_pkg::S_HALT);
  endproperty
  a_halt_abort: assert property (p_halt_abort) else $error("halt did not stop cycle");

  property p_wait_idle;
    @(posedge i_clk) disable iff (i_reset)
    (i_wait_req && !i_halt && !start && state_r == dewc_pkg::S_IDLE) |=> o_wait_ack;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait not entered when idle");

  property p_rop_block;
    @(posedge i_clk) disable iff (i_reset)
    (ee_rd && i_bus.ext && rop_blk && !latch_mode_r)
      |=> (o_rsp.drive && o_rsp.rdata == dewc_pkg::BLOCKED_DATA);
  endproperty
  a_rop_block: assert property (p_rop_block) else $error("protected data read out");

endmodule

// *** dv/dewc_cpu_model.sv ***
// cpu memory bus model that issues single accesses to the eeprom controller
`timescale 1ns/100ps
module dewc_cpu_model (
  input wire logic i_clk,
  output dewc_pkg::dewc_bus_t o_bus,
  input wire dewc_pkg::dewc_rsp_t i_rsp
);
  initial o_bus = '0;

  // one access held for one cycle; afterwards address and data are inverted
  // so a design that samples a released bus never sees the old values
  task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d,
                     input logic x);
    @(posedge i_clk);
    o_bus <= '{rd: rd, wr: ~rd, ext: x, addr: a, wdata: d};
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b0, ext: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic x);
    acc(1'b0, a, d, x);
  endtask

  // the answer is registered, so it is taken just after the taking edge
  task automatic bus_rd(input logic [15:0] a, input logic x, output logic [8:0] r);
    acc(1'b1, a, 8'h00, x);
    #1;
    r = i_rsp;
  endtask
endmodule

// *** dv/dewc_ctrl_bench.sv ***
// self-checking testbench of the data eeprom write controller
`timescale 1ns/100ps
module dewc_ctrl_bench;
  localparam int PROG = 8;
  localparam logic [15:0] CSR = dewc_pkg::CSR_ADDR;
  localparam logic [15:0] EE = dewc_pkg::EE_BASE;

  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wait_req = 1'b0;
  logic i_halt = 1'b0;
  logic i_rop_option = 1'b0;
  dewc_pkg::dewc_bus_t bus;
  dewc_pkg::dewc_rsp_t o_rsp;
  logic o_wait_ack;
  logic o_busy;
  logic o_pmem_erase;
  int error_cnt = 0;
  int comparisons = 0;
  int erase_cnt = 0;
  int n;

  // 40 MHz clock
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  dewc_ctrl #(.PROG_CYCLES(PROG)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .i_wait_req(i_wait_req),
    .i_halt(i_halt), .i_rop_option(i_rop_option), .o_rsp(o_rsp),
    .o_wait_ack(o_wait_ack), .o_busy(o_busy), .o_pmem_erase(o_pmem_erase)
  );

  dewc_cpu_model u_cpu (.i_clk(i_clk), .o_bus(bus), .i_rsp(o_rsp));

  // erase requests are single-cycle pulses, so count them at every edge
  always @(posedge i_clk) begin
    if (o_pmem_erase === 1'b1) erase_cnt++;
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic x = 1'b0);
    u_cpu.bus_wr(a, d, x);
  endtask

  task automatic rd(input logic [15:0] a, input logic [8:0] e, input logic x = 1'b0);
    logic [8:0] r;
    u_cpu.bus_rd(a, x, r);
    chk(r, e);
  endtask

  // bounded wait for the self-timed cycle to end, returns edges counted
  task automatic wait_idle(output int cnt);
    cnt = 0;
    #1;
    while (o_busy === 1'b1 && cnt < 100) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 4000);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    // option low at reset gives one erase, leaving all cells erased
    repeat (10) @(posedge i_clk);
    chk(9'(erase_cnt), 9'h001);
    rd(CSR, 9'h100);
    wr(CSR, 8'hFF);
    rd(CSR, 9'h102);
    wr(CSR, 8'h00);
    rd(CSR, 9'h100);
    rd(CSR + 16'h0001, 9'h000);
    done("register");

    // read mode: cells answer, writes are dropped
    rd(EE + 16'h0005, 9'h1FF);
    wr(EE + 16'h0005, 8'h55);
    rd(EE + 16'h0005, 9'h1FF);
    done("read_mode");

    // one row, rewrite ANDs, latches never readable
    wr(CSR, 8'h02);
    wr(EE + 16'h0005, 8'hAA);
    wr(EE + 16'h0005, 8'hF0);
    wr(EE + 16'h0006, 8'h3C);
    rd(EE + 16'h0005, 9'h000);
    wr(CSR, 8'h03);
    wait_idle(n);
    chk(9'(n), 9'(PROG));
    rd(CSR, 9'h100);
    rd(EE + 16'h0005, 9'h1A0);
    rd(EE + 16'h0006, 9'h13C);
    rd(EE + 16'h0007, 9'h1FF);
    done("program");

    // latch mode fall discards loaded bytes
    wr(CSR, 8'h02);
    wr(EE + 16'h0040, 8'h0F);
    wr(CSR, 8'h00);
    wr(CSR, 8'h02);
    wr(EE + 16'h0041, 8'h11);
    wr(CSR, 8'h03);
    wait_idle(n);
    rd(EE + 16'h0040, 9'h1FF);
    rd(EE + 16'h0041, 9'h111);
    done("latch_clear");

    // wait request during a cycle is deferred until the cycle ends
    wr(CSR, 8'h02);
    wr(EE + 16'h0050, 8'h21);
    wr(CSR, 8'h03);
    i_wait_req <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk({o_busy, 8'(o_wait_ack)}, 9'h100);
    wait_idle(n);
    repeat (3) @(posedge i_clk);
    #1;
    chk(9'(o_wait_ack), 9'h001);
    @(posedge i_clk);
    i_wait_req <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(EE + 16'h0050, 9'h121);
    // idle wait request is honoured at once
    @(posedge i_clk);
    i_wait_req <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(9'(o_wait_ack), 9'h001);
    @(posedge i_clk);
    i_wait_req <= 1'b0;
    repeat (4) @(posedge i_clk);
    done("wait");

    // halt aborts a running cycle immediately
    wr(CSR, 8'h02);
    wr(EE + 16'h0060, 8'h12);
    wr(CSR, 8'h03);
    i_halt <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
    #1;
    chk(9'(o_busy), 9'h000);
    @(posedge i_clk);
    i_halt <= 1'b0;
    repeat (3) @(posedge i_clk);
    wr(CSR, 8'h00);
    rd(EE + 16'h0060, 9'h1FF);
    done("halt");

    // software abort keeps latch mode while the start bit was set
    wr(CSR, 8'h02);
    wr(EE + 16'h0070, 8'h77);
    wr(CSR, 8'h03);
    wr(CSR, 8'h00);
    rd(CSR, 9'h102);
    wr(CSR, 8'h00);
    rd(CSR, 9'h100);
    rd(EE + 16'h0070, 9'h1FF);
    done("abort");

    // protection blocks external reads and rewrites, removal erases all
    @(posedge i_clk);
    i_rop_option <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd(EE + 16'h0041, 9'h100, 1'b1);
    rd(EE + 16'h0041, 9'h111);
    wr(CSR, 8'h02, 1'b1);
    rd(CSR, 9'h100);
    @(posedge i_clk);
    i_rop_option <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(9'(erase_cnt), 9'h002);
    rd(EE + 16'h0041, 9'h1FF);
    done("protect");
    report_and_stop();
  end
endmodule
